/* File: cer_pkg.sv */
// Package for the controller error reporting block.
// Assumes a single 20 MHz clock domain and a plain register port.
`default_nettype none
package cer_pkg;
   // -----------------------------------------------------------------
   // Error codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CODE_TYPE    = 8'hc0;
   localparam logic [7:0] CODE_TIMEOUT = 8'hc1;
   localparam logic [7:0] CODE_RESEL   = 8'h82;
   localparam logic [7:0] CODE_OVERRUN = 8'h83;
   localparam logic [7:0] CODE_DIR     = 8'h84;
   localparam logic [7:0] CODE_SCSI    = 8'h86;
   localparam logic [7:0] CODE_PANIC   = 8'hff;
   // -----------------------------------------------------------------
   // Response status word values
   // -----------------------------------------------------------------
   localparam logic [15:0] RSW_CTRL_ERR = 16'h0085;
   localparam logic [15:0] RSW_SCSI_ERR = 16'h0885;
   localparam int          RSW_VALID_BIT  = 0;
   localparam int          RSW_ERROR_BIT  = 2;
   localparam int          RSW_CHANGE_BIT = 7;
   localparam int          RSW_SCSI_BIT   = 11;
   // -----------------------------------------------------------------
   // Status block layout and diagnostic word
   // -----------------------------------------------------------------
   localparam logic [3:0] BLK_WORD_RSW  = 4'h0;
   localparam logic [3:0] BLK_WORD_CODE = 4'h6;
   localparam logic [3:0] BLK_WORD_DIAG = 4'h7;
   localparam int         DIAG_BUS0_BIT = 12;
   localparam int         DIAG_BUS1_BIT = 13;
   localparam int         OPT_NRSE_BIT  = 2;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h1;
   localparam logic [3:0] REG_RSW     = 4'h2;
   localparam logic [3:0] REG_CODE    = 4'h3;
   localparam logic [3:0] REG_DIAG    = 4'h4;
   localparam logic [3:0] REG_QUEUE   = 4'h5;
   localparam logic [3:0] REG_LEVEL   = 4'h6;
   localparam logic [3:0] REG_OPTIONS = 4'h7;
   localparam int CTRL_ACK_BIT    = 0;
   localparam int CTRL_FREEZE_BIT = 1;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam int PANIC_LEN = 4;
   // Panic text: file, line, description (arbitrary short form)
   localparam logic [7:0] PANIC_TEXT [PANIC_LEN] =
      '{8'h63, 8'h3a, 8'h31, 8'h21};
   typedef enum logic [2:0] {
      CER_IDLE, CER_RSW, CER_CODE, CER_DIAG, CER_TEXT, CER_DONE
   } cer_state_e;
endpackage
`default_nettype wire

/* File: cer_classify.sv */
// Classifier of raw fault events into controller error codes.
// Assumes event inputs are synchronous one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module cer_classify
(
   input  wire logic       type_nz_in,
   input  wire logic       timeout_in,
   input  wire logic       resel_in,
   input  wire logic       overrun_in,
   input  wire logic       dir_in,
   input  wire logic       scsi_in,
   input  wire logic       panic_in,
   input  wire logic       nrse_en_in,
   output logic            hit_out,
   output logic [7:0]      code_out,
   output logic            blk_valid_out,
   output logic            is_panic_out
);
   import cer_pkg::*;
   // Unreported SCSI faults turn into a panic
   wire scsi_panic = scsi_in & ~nrse_en_in;
   wire any_panic  = panic_in | scsi_panic;
   assign hit_out = type_nz_in | timeout_in | resel_in | overrun_in |
                    dir_in | scsi_in | panic_in;
   assign is_panic_out = any_panic;
   // Priority: panic, scsi, type, timeout, resel, overrun, direction
   assign code_out =
      any_panic  ? CODE_PANIC   :
      scsi_in    ? CODE_SCSI    :
      type_nz_in ? CODE_TYPE    :
      timeout_in ? CODE_TIMEOUT :
      resel_in   ? CODE_RESEL   :
      overrun_in ? CODE_OVERRUN :
                   CODE_DIR;
   // Reselection leaves the block fields invalid
   assign blk_valid_out = ~(code_out == CODE_RESEL);
endmodule
`default_nettype wire

/* File: cer_top.sv */
// Controller error reporting block: classifies faults, writes the
// error status block into shared memory and tracks queue freezes.
// Assumes a synchronous shared memory write port and a host that
// acknowledges each report through the control register.
// Operation
// - Controller error code goes in word 6 of the status block.
// - Type error C0, timeout C1, unknown reselection 82.
// - Overrun 83, direction mismatch 84, non-recoverable SCSI 86.
// - Panic reports FF followed by ASCII file, line, description.
// - Panic text goes only to onboard memory, never offboard.
// - Controller error reports never freeze a work queue.
// - Nonzero parameter block type raises error C0.
// - Timed-out block stays active until completed or cancelled.
// - Reselection report marks other status block fields invalid.
// - Exhausted counters with more data requested raise 83.
// - Direction bit disagreeing with target raises 84.
// - For 86 the command tag is valid only when nonzero.
// - Enabled SCSI faults report status word 0885 with interrupt.
// - Diagnostic word: code bits 0-11, bus0 bit 12, bus1 bit 13.
// - Disabled SCSI fault reporting causes panic; reinit needed.
// - Bus reset returns active commands; freezes queues if chosen.
// - Unflushed queue resumes once bus free and command cleared.
// - Flush leaves bus-active commands; those end otherwise.
// - General controller error status word reads 0085.
// - Level 0 means no interrupt but still posts the block.
`timescale 1ns/1ps
`default_nettype none
module cer_top
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Fault events
   input  wire logic        type_nz_in,
   input  wire logic        timeout_in,
   input  wire logic        resel_in,
   input  wire logic        overrun_in,
   input  wire logic        dir_in,
   input  wire logic        scsi_in,
   input  wire logic        panic_in,
   input  wire logic [11:0] scsi_code_in,
   input  wire logic        scsi_bus1_in,
   input  wire logic [7:0]  queue_in,
   // Queue control events
   input  wire logic        bus_reset_in,
   input  wire logic        complete_in,
   input  wire logic        cancel_in,
   input  wire logic        flush_in,
   input  wire logic        bus_free_in,
   input  wire logic        offboard_in,
   // Register port
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [15:0] reg_rdata_out,
   // Shared memory write port
   output logic             mem_we_out,
   output logic      [3:0]  mem_addr_out,
   output logic      [15:0] mem_wdata_out,
   output logic             mem_offboard_out,
   // Controller error interrupt and queue state
   output logic             irq_out,
   output logic             held_out,
   output logic             frozen_out,
   output logic             issue_ok_out,
   output logic             reset_ret_out,
   output logic             need_reinit_out
);
   import cer_pkg::*;
   // -----------------------------------------------------------------
   // Classification
   // -----------------------------------------------------------------
   logic       hit;
   logic [7:0] code;
   logic       blk_valid;
   logic       is_panic;
   logic       nrse_en_q;
   cer_classify u_class
   (
      .type_nz_in    (type_nz_in),
      .timeout_in    (timeout_in),
      .resel_in      (resel_in),
      .overrun_in    (overrun_in),
      .dir_in        (dir_in),
      .scsi_in       (scsi_in),
      .panic_in      (panic_in),
      .nrse_en_in    (nrse_en_q),
      .hit_out       (hit),
      .code_out      (code),
      .blk_valid_out (blk_valid),
      .is_panic_out  (is_panic)
   );
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   cer_state_e  state_q, state_d;
   logic [15:0] rsw_q;
   logic [7:0]  code_q;
   logic [15:0] diag_q;
   logic [7:0]  queue_q;
   logic [7:0]  level_q;
   logic [15:0] opts_q;
   logic        valid_q;
   logic        busy_q;
   logic        pend_q;
   logic        freeze_opt_q;
   logic        frozen_q;
   logic        held_q;
   logic        flushed_q;
   logic        reinit_q;
   logic        irq_q;
   logic [1:0]  txt_q;
   logic [15:0] rdata_q;
   logic        we_q;
   logic [3:0]  addr_q;
   logic [15:0] wdata_q;
   logic        off_q;
   assign nrse_en_q = opts_q[OPT_NRSE_BIT];
   wire wr_ctrl  = reg_wr_in & (reg_addr_in == REG_CTRL);
   wire wr_level = reg_wr_in & (reg_addr_in == REG_LEVEL);
   wire wr_opts  = reg_wr_in & (reg_addr_in == REG_OPTIONS);
   wire ack      = wr_ctrl & reg_wdata_in[CTRL_ACK_BIT];
   wire take     = hit & ~busy_q & ~reinit_q;
   wire scsi_rep = take & scsi_in & nrse_en_q;
   // -----------------------------------------------------------------
   // Status word and diagnostic word
   // -----------------------------------------------------------------
   wire [15:0] rsw_new = scsi_rep ? RSW_SCSI_ERR
                                  : RSW_CTRL_ERR;
   wire [15:0] diag_new = {2'b00,
                           scsi_bus1_in, ~scsi_bus1_in, scsi_code_in};
   // -----------------------------------------------------------------
   // Posting sequence
   // -----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         CER_IDLE: if (take) state_d = CER_RSW;
         CER_RSW:  state_d = CER_CODE;
         CER_CODE:
            if (code_q == CODE_SCSI) state_d = CER_DIAG;
            else if (code_q == CODE_PANIC) state_d = CER_TEXT;
            else state_d = CER_DONE;
         CER_DIAG: state_d = CER_DONE;
         CER_TEXT:
            if (txt_q == 2'(PANIC_LEN - 1)) state_d = CER_DONE;
         CER_DONE: if (ack) state_d = CER_IDLE;
         default:  state_d = CER_IDLE;
      endcase
   end
   wire [15:0] txt_word = {8'h00, PANIC_TEXT[txt_q]};
   wire        mem_we_d = (state_q == CER_RSW) | (state_q == CER_CODE) |
                          (state_q == CER_DIAG) | (state_q == CER_TEXT);
   wire [3:0]  mem_addr_d =
      (state_q == CER_RSW)  ? BLK_WORD_RSW  :
      (state_q == CER_CODE) ? BLK_WORD_CODE :
      (state_q == CER_DIAG) ? BLK_WORD_DIAG :
                              4'(BLK_WORD_DIAG + 4'(txt_q));
   wire [15:0] mem_data_d =
      (state_q == CER_RSW)  ? rsw_q :
      (state_q == CER_CODE) ? {8'h00, code_q} :
      (state_q == CER_DIAG) ? diag_q : txt_word;
   // Panic text never goes to host memory
   wire off_d = offboard_in & (state_q != CER_TEXT)
                & (code_q != CODE_PANIC);
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= CER_IDLE;
         txt_q   <= 2'b00;
         we_q    <= 1'b0;
         addr_q  <= 4'h0;
         wdata_q <= RST_ZERO;
         off_q   <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         txt_q   <= (state_q == CER_TEXT) ? 2'(txt_q + 2'b01) : 2'b00;
         we_q    <= mem_we_d;
         addr_q  <= mem_addr_d;
         wdata_q <= mem_data_d;
         off_q   <= off_d & mem_we_d;
      end
   end
   assign busy_q = (state_q != CER_IDLE);
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         rsw_q   <= RST_ZERO;
         code_q  <= 8'h00;
         diag_q  <= RST_ZERO;
         queue_q <= 8'h00;
         valid_q <= 1'b0;
      end
      else if (take)
      begin
         rsw_q   <= rsw_new;
         code_q  <= code;
         diag_q  <= scsi_rep ? diag_new : RST_ZERO;
         queue_q <= queue_in;
         valid_q <= blk_valid;
      end
   end
   // -----------------------------------------------------------------
   // Interrupt, reinit and configuration
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         level_q      <= 8'h00;
         opts_q       <= RST_ZERO;
         freeze_opt_q <= 1'b0;
         irq_q        <= 1'b0;
         reinit_q     <= 1'b0;
      end
      else
      begin
         if (wr_level) level_q <= reg_wdata_in[7:0];
         if (wr_opts) opts_q <= reg_wdata_in;
         if (wr_ctrl) freeze_opt_q <= reg_wdata_in[CTRL_FREEZE_BIT];
         // Interrupt only with nonzero level; posting happens anyway
         if ((state_d == CER_DONE) && (state_q != CER_DONE))
            irq_q <= (level_q != 8'h00);
         else if (ack)
            irq_q <= 1'b0;
         // Panic sticks until full reinitialization
         if (take & is_panic) reinit_q <= 1'b1;
         else if (wr_opts) reinit_q <= 1'b0;
      end
   end
   // -----------------------------------------------------------------
   // Queue behaviour
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         held_q    <= 1'b0;
         frozen_q  <= 1'b0;
         flushed_q <= 1'b0;
         pend_q    <= 1'b0;
      end
      else
      begin
         // Timed-out block held until it completes, is cancelled or reset
         if (take & timeout_in & ~is_panic & ~scsi_in & ~type_nz_in)
            held_q <= 1'b1;
         else if (complete_in | cancel_in | bus_reset_in)
            held_q <= 1'b0;
         // Only bus reset may freeze; errors never do
         if (bus_reset_in & freeze_opt_q)
            frozen_q <= 1'b1;
         else if (wr_ctrl & ~reg_wdata_in[CTRL_FREEZE_BIT])
            frozen_q <= 1'b0;
         if (flush_in) flushed_q <= 1'b1;
         else if (wr_opts) flushed_q <= 1'b0;
         pend_q <= bus_reset_in;
      end
   end
   // Issue resumes once the bus is free, the held command cleared and no freeze, flush or reinit is pending
   assign issue_ok_out = bus_free_in & ~held_q & ~frozen_q
                         & ~flushed_q & ~reinit_q;
   // -----------------------------------------------------------------
   // Register read
   // -----------------------------------------------------------------
   wire [15:0] status_word = {11'h000, reinit_q, flushed_q, frozen_q,
                              held_q, valid_q};
   // Tag field valid only when nonzero for SCSI faults
   wire [15:0] queue_word = {7'h00,
      (code_q == CODE_SCSI) ? (queue_q != 8'h00) : valid_q,
      queue_q};
   wire [15:0] rd_mux =
      (reg_addr_in == REG_STATUS)  ? status_word :
      (reg_addr_in == REG_RSW)     ? rsw_q :
      (reg_addr_in == REG_CODE)    ? {8'h00, code_q} :
      (reg_addr_in == REG_DIAG)    ? diag_q :
      (reg_addr_in == REG_QUEUE)   ? queue_word :
      (reg_addr_in == REG_LEVEL)   ? {8'h00, level_q} :
      (reg_addr_in == REG_OPTIONS) ? opts_q : RST_ZERO;
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in) rdata_q <= RST_ZERO;
      else rdata_q <= reg_rd_in ? rd_mux : RST_ZERO;
   end
   assign reg_rdata_out    = rdata_q;
   assign mem_we_out       = we_q;
   assign mem_addr_out     = addr_q;
   assign mem_wdata_out    = wdata_q;
   assign mem_offboard_out = off_q;
   assign irq_out          = irq_q;
   assign held_out         = held_q;
   assign frozen_out       = frozen_q;
   assign reset_ret_out    = pend_q;
   assign need_reinit_out  = reinit_q;
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence code_write_s;
      mem_we_out && mem_addr_out == BLK_WORD_CODE;
   endsequence
   code_word_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == CER_CODE) |=> code_write_s)
      else $error("code word not written");
   type_code_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (take && type_nz_in && !panic_in && !scsi_in) |=>
      code_q == CODE_TYPE)
      else $error("type error code wrong");
   panic_off_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (mem_we_out && code_q == CODE_PANIC) |-> !mem_offboard_out)
      else $error("panic posted offboard");
   scsi_rsw_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      scsi_rep |=> rsw_q == RSW_SCSI_ERR ##1 mem_wdata_out == RSW_SCSI_ERR)
      else $error("scsi status word wrong");
   ctrl_rsw_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (take && !scsi_rep) |=> rsw_q == RSW_CTRL_ERR)
      else $error("controller status word wrong");
   // Written diagnostic word: reserved bits clear, exactly one channel bit
   diag_zero_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (mem_we_out && mem_addr_out == BLK_WORD_DIAG && code_q == CODE_SCSI)
      |-> (mem_wdata_out[15:14] == 2'b00 && ^mem_wdata_out[13:12]))
      else $error("diag word malformed");
   no_freeze_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ($rose(frozen_q)) |-> $past(bus_reset_in))
      else $error("freeze without bus reset");
   level_irq_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (level_q == 8'h00 && !wr_level) |=> !$rose(irq_q))
      else $error("interrupt at level zero");
   panic_lock_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (take && scsi_in && !nrse_en_q) |=> reinit_q)
      else $error("missing panic lock");
   resel_inv_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (take && code == CODE_RESEL) |=> !valid_q)
      else $error("reselection block marked valid");
endmodule
`default_nettype wire

/* File: cer_host_mem.sv */
// Host side model of the shared memory that receives status blocks.
// Assumes one registered word per write pulse from the block.
`timescale 1ns/1ps
`default_nettype none
module cer_host_mem
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        mem_we_in,
   input  wire logic [3:0]  mem_addr_in,
   input  wire logic [15:0] mem_wdata_in,
   input  wire logic        mem_offboard_in
);
   logic [15:0] onboard_q  [16];
   logic [15:0] offboard_q [16];
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < 16; i++)
         begin
            onboard_q[i]  <= 16'h0000;
            offboard_q[i] <= 16'h0000;
         end
      end
      else if (mem_we_in)
      begin
         onboard_q[mem_addr_in] <= mem_wdata_in;
         // Host memory image follows mirrored words only
         if (mem_offboard_in)
            offboard_q[mem_addr_in] <= mem_wdata_in;
      end
   end
endmodule
`default_nettype wire

/* File: cer_top_bench.sv */
// Self-checking bench for the controller error reporting block.
// Assumes cer_pkg and the shared memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cer_top_bench;
   import cer_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [10:0] ev;
   logic [11:0] scode;
   logic        bus1, bus_free, offboard, wr, rd;
   logic [7:0]  queue;
   logic [3:0]  addr;
   logic [15:0] wdata, got;
   wire  [15:0] rdata, mwdata;
   wire  [3:0]  maddr;
   wire         mwe, moff, irq, held, frozen, issue_ok, rret, reinit;
   int          fail_count, cmp_count, cycles;
   logic [7:0]  codes [5] =
      '{CODE_TYPE, CODE_TIMEOUT, CODE_RESEL, CODE_OVERRUN, CODE_DIR};
   logic [4:0]  vld = 5'b11011;
   always #25 clk_in = ~clk_in;
   cer_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .type_nz_in(ev[0]), .timeout_in(ev[1]), .resel_in(ev[2]),
      .overrun_in(ev[3]), .dir_in(ev[4]), .scsi_in(ev[5]),
      .panic_in(ev[6]), .scsi_code_in(scode), .scsi_bus1_in(bus1),
      .queue_in(queue), .bus_reset_in(ev[7]), .complete_in(ev[8]),
      .cancel_in(ev[9]), .flush_in(ev[10]), .bus_free_in(bus_free),
      .offboard_in(offboard), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwdata),
      .mem_offboard_out(moff), .irq_out(irq), .held_out(held),
      .frozen_out(frozen), .issue_ok_out(issue_ok),
      .reset_ret_out(rret), .need_reinit_out(reinit));
   cer_host_mem hm (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .mem_we_in(mwe), .mem_addr_in(maddr), .mem_wdata_in(mwdata),
      .mem_offboard_in(moff));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic give_verdict();
      if (fail_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e)
      begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         fail_count++;
      end
   endtask
   task automatic bit_chk(input logic g, input logic e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic pulse(input int b);
      @(posedge clk_in);
      ev <= 11'h001 << b;
      @(posedge clk_in);
      ev <= 11'h000;
      #1;
   endtask
   // Raise one fault, wait for the block, check it, then acknowledge
   task automatic report(input int b, input logic [7:0] code,
                         input logic [15:0] rsw, input logic irq_e);
      int n;
      n = 0;
      pulse(b);
      while (irq !== 1'b1 && n < 20)
      begin
         @(posedge clk_in);
         #1 n++;
      end
      // Last word lands in memory one edge after the interrupt rises
      @(posedge clk_in);
      #1;
      chk(hm.onboard_q[BLK_WORD_RSW], rsw);
      chk(hm.onboard_q[BLK_WORD_CODE], {8'h00, code});
      bit_chk(irq, irq_e);
      bit_chk(frozen, 1'b0);
      wr_reg(REG_CTRL, 16'h0001);
      bit_chk(irq, 1'b0);
   endtask
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   initial
   begin
      ev = '0; scode = '0; bus1 = 0; bus_free = 0; offboard = 0;
      queue = '0; addr = '0; wdata = '0; wr = 0; rd = 0;
      fail_count = 0; cmp_count = 0; cycles = 0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      wr_reg(REG_LEVEL, 16'h0001);
      wr_reg(REG_OPTIONS, 16'h0004);
      for (int i = 0; i < 5; i++)
      begin
         queue <= 8'(i + 1);
         report(i, codes[i], RSW_CTRL_ERR, 1'b1);
         rd_reg(REG_STATUS, got);
         bit_chk(got[0], vld[i]);
      end
      bit_chk(held, 1'b1);
      bus_free <= 1'b1;
      pulse(10);
      bit_chk(held, 1'b1);
      bit_chk(issue_ok, 1'b0);
      pulse(8);
      bit_chk(held, 1'b0);
      wr_reg(REG_OPTIONS, 16'h0004);
      bit_chk(issue_ok, 1'b1);
      report(1, CODE_TIMEOUT, RSW_CTRL_ERR, 1'b1);
      pulse(9);
      bit_chk(held, 1'b0);
      for (int b = 0; b < 2; b++)
      begin
         scode <= 12'habc;
         bus1  <= b[0];
         queue <= b[0] ? 8'h05 : 8'h00;
         report(5, CODE_SCSI, RSW_SCSI_ERR, 1'b1);
         chk(hm.onboard_q[BLK_WORD_DIAG], b[0] ? 16'h2abc : 16'h1abc);
         rd_reg(REG_QUEUE, got);
         chk(got, b[0] ? 16'h0105 : 16'h0000);
      end
      pulse(7);
      bit_chk(rret, 1'b1);
      wr_reg(REG_LEVEL, 16'h0000);
      report(4, CODE_DIR, RSW_CTRL_ERR, 1'b0);
      rd_reg(REG_CODE, got);
      chk(got, {8'h00, CODE_DIR});
      rd_reg(4'hf, got);
      chk(got, 16'h0000);
      wr_reg(REG_LEVEL, 16'h0001);
      wr_reg(REG_OPTIONS, 16'h0000);
      offboard <= 1'b1;
      report(5, CODE_PANIC, RSW_CTRL_ERR, 1'b1);
      bit_chk(reinit, 1'b1);
      for (int k = 0; k < PANIC_LEN; k++)
      begin
         chk(hm.onboard_q[7 + k], {8'h00, PANIC_TEXT[k]});
         chk(hm.offboard_q[7 + k], 16'h0000);
      end
      offboard <= 1'b0;
      wr_reg(REG_OPTIONS, 16'h0004);
      bit_chk(reinit, 1'b0);
      report(1, CODE_TIMEOUT, RSW_CTRL_ERR, 1'b1);
      wr_reg(REG_CTRL, 16'h0002);
      rd_reg(REG_STATUS, got);
      chk(got, 16'h0003);
      pulse(7);
      bit_chk(rret, 1'b1);
      bit_chk(frozen, 1'b1);
      bit_chk(held, 1'b0);
      bit_chk(issue_ok, 1'b0);
      wr_reg(REG_CTRL, 16'h0000);
      bit_chk(frozen, 1'b0);
      bit_chk(issue_ok, 1'b1);
      pulse(7);
      bit_chk(frozen, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
